// ### rtl/mbs_core.sv
`timescale 1ns/1ns
// Summary of operation
// R1: Command bit 15 clears overvoltage flag and releases outputs it forced off.
// R2: Command bits 0 and 15 both high clear whole status at chip select rise.
// R3: Command bit 14 clears over-temperature flag and releases forced outputs.
// R4: Command bit 13 clears overcurrent flag and releases forced outputs.
// R5: Status bit 15 latches supply overvoltage until cleared by command.
// R6: Status bit 14 latches thermal shutdown until cleared by command.
// R7: Status bit 13 latches overcurrent until cleared by command.
// R8: Command bits 12..9 drive C2 low, C2 high, C1 low, C1 high switches.
// R9: Status bits 12..9 report those four switch states in same order.
// R10: Master gives each device its own select and enables one at a time.
// R11: After reset all command and status bits are low.
// R12: Input sampled on falling clock, output changes on rising, MSB first.
// R13: On chip select rise the word loads and bits 1..12 drive switches.
// R14: Transfers shorter than 15 or longer than 17 bits are discarded.
// R15: Serial output is released while chip select is high.
module mbs_core
	import mbs_pkg::*;
(
	// System
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	// Serial link from master
	input wire logic SCLK,
	input wire logic CHIP_SELECT_N,
	input wire logic SDI,
	output logic SDO,
	output logic SDO_OE_N,
	// Fault detector levels
	input wire logic OVERVOLTAGE_DET,
	input wire logic OVERTEMP_DET,
	input wire logic OVERCURRENT_DET,
	// Switch controls, bits 1..12 of the command word
	output logic [SW_HI:SW_LO] SWITCH_CTRL,
	// Outputs forced off by faults
	output logic FAULT_OFF
);
	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic [2:0] fmeta_q;
	logic [2:0] fault_q;
	logic sclk_old_q;
	logic cs_old_q;
	// Two flops per pin; the first stage feeds only the second
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			// Idle pin levels, so no false edge follows reset
			meta_q <= 3'h4;
			sync_q <= 3'h4;
			fmeta_q <= 3'h0;
			fault_q <= 3'h0;
			sclk_old_q <= 1'b0;
			cs_old_q <= 1'b1;
		end else if (CLK_EN) begin
			meta_q <= {CHIP_SELECT_N, SCLK, SDI};
			sync_q <= meta_q;
			fmeta_q <= {OVERVOLTAGE_DET, OVERTEMP_DET, OVERCURRENT_DET};
			fault_q <= fmeta_q;
			sclk_old_q <= sync_q[1];
			cs_old_q <= sync_q[2];
		end
	end
	// ---------------------------------------------------------------
	// Edge decode
	// ---------------------------------------------------------------
	wire cs_n = sync_q[2];
	wire sclk_s = sync_q[1];
	wire sdi_s = sync_q[0];
	wire sclk_fall = !cs_n && sclk_old_q && !sclk_s;
	wire sclk_rise = !cs_n && !sclk_old_q && sclk_s;
	wire cs_fall = cs_old_q && !cs_n;
	wire cs_rise = !cs_old_q && cs_n;
	// ---------------------------------------------------------------
	// Shift registers and bit counter
	// ---------------------------------------------------------------
	logic [WORD_W-1:0] rx_q;
	logic [WORD_W-1:0] tx_q;
	logic [4:0] cnt_q;
	logic [WORD_W-1:0] cmd_q;
	logic [WORD_W-1:0] stat_q;
	logic sdo_q;
	logic sdo_oe_n_q;
	// Saturate so long transfers stay rejected
	wire [4:0] cnt_inc = (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
	wire len_ok = (cnt_q >= LEN_MIN) && (cnt_q <= LEN_MAX);
	wire accept = cs_rise && len_ok;
	// Sample on falling clock, shift out on rising
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			rx_q <= CMD_RESET;
			tx_q <= STAT_RESET;
			cnt_q <= 5'h00;
			sdo_q <= 1'b0;
			sdo_oe_n_q <= 1'b1;
		end else if (CLK_EN) begin
			sdo_oe_n_q <= cs_n; // [R15]
			if (cs_fall) begin
				tx_q <= {stat_q[WORD_W-2:0], 1'b0};
				sdo_q <= stat_q[WORD_W-1]; // [R12]
				cnt_q <= 5'h00;
			end else begin
				if (sclk_fall) begin
					rx_q <= {rx_q[WORD_W-2:0], sdi_s}; // [R12]
					cnt_q <= cnt_inc;
				end
				// First rise is the leading edge; only later rises advance
				if (sclk_rise && (cnt_q != 5'h00)) begin
					sdo_q <= tx_q[WORD_W-1]; // [R12]
					tx_q <= {tx_q[WORD_W-2:0], 1'b0};
				end
			end
		end
	end
	// ---------------------------------------------------------------
	// Command register and fault flags
	// ---------------------------------------------------------------
	// With 17 clocks the first bit has fallen out; last 16 are kept
	wire pair_clr = accept && rx_q[BIT_PAIR] && rx_q[BIT_OV]; // [R2]
	wire ov_clr = accept && rx_q[BIT_OV]; // [R1]
	wire ot_clr = accept && rx_q[BIT_OT]; // [R3]
	wire oc_clr = accept && rx_q[BIT_OC]; // [R4]
	// Detector set wins over a clear arriving in the same cycle
	wire ov_d = fault_q[2] | (stat_q[BIT_OV] & ~(ov_clr | pair_clr)); // [R5]
	wire ot_d = fault_q[1] | (stat_q[BIT_OT] & ~(ot_clr | pair_clr)); // [R6]
	wire oc_d = fault_q[0] | (stat_q[BIT_OC] & ~(oc_clr | pair_clr)); // [R7]
	wire [WORD_W-1:0] cmd_d = accept ? rx_q : cmd_q; // [R13] [R14]
	wire any_flag = ov_d | ot_d | oc_d;
	// Pair clear also drops switch echoes; switches resume next word
	wire [SW_HI:SW_LO] sw_now = pair_clr ? '0 : cmd_d[SW_HI:SW_LO];
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			cmd_q <= CMD_RESET; // [R11]
			stat_q <= STAT_RESET; // [R11]
		end else if (CLK_EN) begin
			cmd_q <= pair_clr ? CMD_RESET : cmd_d; // [R2]
			stat_q[BIT_OV] <= ov_d;
			stat_q[BIT_OT] <= ot_d;
			stat_q[BIT_OC] <= oc_d;
			// Echo real switch states, off while a fault holds them
			stat_q[SW_HI:SW_LO] <= any_flag ? '0 : sw_now; // [R9]
			stat_q[BIT_PAIR] <= 1'b0;
		end
	end
	// ---------------------------------------------------------------
	// Output drive
	// ---------------------------------------------------------------
	logic [SW_HI:SW_LO] sw_q;
	logic fault_off_q;
	// All outputs stay off while any fault flag is set, until every flag is cleared
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			sw_q <= '0;
			fault_off_q <= 1'b0;
		end else if (CLK_EN) begin
			sw_q <= any_flag ? '0 : sw_now; // [R8] [R13] [R1]
			fault_off_q <= any_flag;
		end
	end
	assign SWITCH_CTRL = sw_q;
	assign FAULT_OFF = fault_off_q;
	assign SDO = sdo_q;
	assign SDO_OE_N = sdo_oe_n_q;
	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	hiz_idle_a: assert property (CLK_EN && cs_n |=> SDO_OE_N) // [R15]
		else $error("serial output driven while deselected");
	bad_len_a: assert property (CLK_EN && cs_rise && !len_ok |=> $stable(cmd_q)) // [R14]
		else $error("bad length transfer changed command");
	load_a: assert property (CLK_EN && accept && !pair_clr |=> cmd_q == $past(rx_q)) // [R13]
		else $error("command not loaded at select rise");
	pair_a: assert property (CLK_EN && pair_clr && !fault_q[2] |=> !stat_q[BIT_OV]) // [R2]
		else $error("pair clear left overvoltage set");
	ov_hold_a: assert property (stat_q[BIT_OV] && !accept && CLK_EN |=> stat_q[BIT_OV]) // [R5]
		else $error("overvoltage flag dropped without clear");
	ot_hold_a: assert property (stat_q[BIT_OT] && !accept && CLK_EN |=> stat_q[BIT_OT]) // [R6]
		else $error("temperature flag dropped without clear");
	oc_set_a: assert property (CLK_EN && fault_q[0] |=> stat_q[BIT_OC]) // [R7]
		else $error("overcurrent flag not set");
	ov_clr_a: assert property (CLK_EN && ov_clr && !fault_q[2] |=> !stat_q[BIT_OV]) // [R1]
		else $error("overvoltage clear ignored");
	ot_clr_a: assert property (CLK_EN && ot_clr && !fault_q[1] |=> !stat_q[BIT_OT]) // [R3]
		else $error("temperature clear ignored");
	oc_clr_a: assert property (CLK_EN && oc_clr && !fault_q[0] |=> !stat_q[BIT_OC]) // [R4]
		else $error("overcurrent clear ignored");
	sw_off_a: assert property (fault_off_q |-> SWITCH_CTRL == '0) // [R8]
		else $error("switch on during fault");
	echo_a: assert property (stat_q[SW_HI:SW_LO] == SWITCH_CTRL) // [R9]
		else $error("status echo differs from switches");
	shift_a: assert property (CLK_EN && sclk_fall && !cs_fall |=> rx_q[0] == $past(sdi_s)) // [R12]
		else $error("input not sampled on falling clock");
	// Flags set from the synchronised detectors, and the overcurrent flag hold
	ov_set_a: assert property (CLK_EN && fault_q[2] |=> stat_q[BIT_OV]) // [R5]
		else $error("overvoltage flag not set");
	ot_set_a: assert property (CLK_EN && fault_q[1] |=> stat_q[BIT_OT]) // [R6]
		else $error("temperature flag not set");
	oc_hold_a: assert property (stat_q[BIT_OC] && !accept && CLK_EN |=> stat_q[BIT_OC]) // [R7]
		else $error("overcurrent flag dropped without clear");
	// Serial side: first bit, drive enable, idle shift register
	first_bit_a: assert property (CLK_EN && cs_fall |=> SDO == $past(stat_q[BIT_OV])) // [R12]
		else $error("first serial bit is not the top status bit");
	oe_drive_a: assert property (CLK_EN && !cs_n |=> !SDO_OE_N) // [R15]
		else $error("serial output released while selected");
	idle_rx_a: assert property (CLK_EN && cs_n |=> $stable(rx_q)) // [R12]
		else $error("input shifted while deselected");
	// Command register after pair clear and against the switch drives
	pair_cmd_a: assert property (CLK_EN && pair_clr |=> cmd_q == CMD_RESET) // [R2]
		else $error("pair clear left command word set");
	cmd_echo_a: assert property (!fault_off_q |-> SWITCH_CTRL == cmd_q[SW_HI:SW_LO]) // [R13]
		else $error("switch drive differs from command word");
	cov_long_c: cover property (accept && cnt_q == LEN_MAX);
	cov_word_c: cover property (accept && !pair_clr);
	cov_bad_c: cover property (cs_rise && !len_ok);
	cov_pair_c: cover property (pair_clr);
	cov_fault_c: cover property (fault_off_q ##1 !fault_off_q);
endmodule : mbs_core

// ### rtl/mbs_pkg.sv
package mbs_pkg;
	// ---------------------------------------------------------------
	// Word layout
	// ---------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int BIT_OV = 15;
	localparam int BIT_OT = 14;
	localparam int BIT_OC = 13;
	localparam int BIT_C2L = 12;
	localparam int BIT_C2H = 11;
	localparam int BIT_C1L = 10;
	localparam int BIT_C1H = 9;
	localparam int BIT_PAIR = 0;
	localparam int SW_LO = 1;
	localparam int SW_HI = 12;
	// Accepted transfer lengths, inclusive
	localparam logic [4:0] LEN_MIN = 5'h0F;
	localparam logic [4:0] LEN_MAX = 5'h11;
	// Reset values
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	// Synchroniser depth in cycles
	localparam int SYNC_STAGES = 2;
endpackage : mbs_pkg

// ### verification/mbs_master_model.sv
`timescale 1ns/1ns
module mbs_master_model (
	// Link to the device
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe_n
);
	// ---------------------------------------------------------------
	// Serial master
	// ---------------------------------------------------------------
	logic [15:0] rx_q;
	event done_e;
	// Released pin has no pull; show the inverse so a late sample shows up
	wire so_pin = sdo_oe_n ? ~sdo : sdo;

	// Idle at the pull levels, clock stands still between frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1; // own select, one device only
		sdi = 1'b0;
		rx_q = 16'h0000;
	end

	// One frame of n bits, top bit first; only 16-bit frames report
	task automatic xfer(input int n, input logic [17:0] w);
		cs_n <= 1'b0;
		rx_q = 16'h0000;
		#250;
		for (int i = n - 1; i >= 0; i--) begin
			sclk <= 1'b1;
			sdi <= w[i]; // data changes on rise
			#62;
			sclk <= 1'b0;
			rx_q = {rx_q[14:0], so_pin}; // read on fall
			#63;
		end
		sdi <= 1'b0;
		#250 cs_n <= 1'b1;
		#250;
		if (n == 16) begin
			-> done_e;
		end
		// Let the watcher read this frame before the next one clears it
		#8;
	endtask : xfer
endmodule : mbs_master_model

// ### verification/test_motor_bridge_spi_command_status.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module test_motor_bridge_spi_command_status;
	import mbs_pkg::*;
	// ---------------------------------------------------------------
	// Harness
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [2:0] det = 3'h0;
	logic sclk, cs_n, sdi, sdo, sdo_oe_n, fault_off;
	logic [12:1] sw;
	logic [29:0] exp_q[$];
	logic [15:0] cmd, w;
	logic [2:0] flg;
	int num_errors = 0;
	int check_count = 0;
	int seed = 81;

	// Clock, 8 ns period
	always #4 clk = ~clk;

	mbs_core dut (.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .SCLK(sclk),
		.CHIP_SELECT_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE_N(sdo_oe_n),
		.OVERVOLTAGE_DET(det[2]), .OVERTEMP_DET(det[1]), .OVERCURRENT_DET(det[0]),
		.SWITCH_CTRL(sw), .FAULT_OFF(fault_off));
	mbs_master_model m (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

	// Note the status read during the frame and the state after it
	task automatic send(input logic [15:0] v);
		logic [15:0] s;
		s = {flg, (|flg) ? 12'h000 : cmd[12:1], 1'b0};
		flg = (v[15] & v[0]) ? 3'h0 : flg & ~v[15:13];
		cmd = (v[15] & v[0]) ? 16'h0000 : v;
		exp_q.push_back({s, 1'b1, |flg, (|flg) ? 12'h000 : cmd[12:1]});
		m.xfer(16, {2'b00, v});
	endtask : send

	// Short detector pulse; the flag must outlive it
	task automatic trip(input int k);
		@(posedge clk) det[k] <= 1'b1;
		repeat (6) @(posedge clk);
		det[k] <= 1'b0;
		flg[k] = 1'b1;
	endtask : trip

	task automatic tally_and_finish();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	// Watcher: oldest note against each finished 16-bit frame
	always begin : watch
		logic [29:0] e;
		@(m.done_e);
		e = exp_q.pop_front();
		`CHK("readback", e, {m.rx_q, sdo_oe_n, fault_off, sw})
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		cmd = 16'h0000;
		flg = 3'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		repeat (4) send(16'($random(seed)) & 16'h1FFF);
		// Frozen clock enable hides a detector pulse and keeps the word
		@(posedge clk) clk_en <= 1'b0;
		@(posedge clk) det[1] <= 1'b1;
		repeat (6) @(posedge clk);
		det[1] <= 1'b0;
		repeat (4) @(posedge clk);
		clk_en <= 1'b1;
		send(cmd);
		// Each fault latches through an empty word, then its own clear releases it
		for (int k = 2; k >= 0; k--) begin
			trip(k);
			send(16'h0000);
			send(16'h2000 << k);
		end
		// Pair clear wipes flags and switch word alike
		send(16'h1E00);
		trip(2);
		trip(0);
		send(16'h8001);
		send(16'h0000);
		// Bad lengths leave state alone; 17 bits drops the first
		w = 16'($random(seed)) & 16'h1FFE;
		m.xfer(14, 18'($random(seed)));
		m.xfer(18, 18'($random(seed)));
		send(cmd);
		m.xfer(17, {2'b01, w});
		cmd = w;
		send(w);
		send(16'h0000);
		// 15 bits are kept too; the top bit is the stale low bit of the last word
		m.xfer(15, {2'b00, w});
		cmd = w;
		send(16'h0000);
		for (int i = 0; i < 100 && exp_q.size() != 0; i++) @(posedge clk);
		if (exp_q.size() != 0) num_errors++;
		tally_and_finish();
	end
endmodule : test_motor_bridge_spi_command_status
